// *** bench/pad_far_side.sv ***
// Far-side pad load: outside drivers, pull-ups and floating lines
`default_nettype none
module pad_far_side (
  input wire logic clk_sys,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] drv_en,
  input wire logic [7:0] drv_val,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q;
  initial last_q = 8'h00;
  // Device driver wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (drv_en[i]) pad_in[i] = drv_val[i];
      else if (pull_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_q[i];
    end
  end
  // Floating line flips every cycle
  always @(posedge clk_sys) begin
    last_q <= pad_in;
  end
endmodule
`default_nettype wire

// *** bench/port_alt_chk.sv ***
// Checker for the port override block, bound to its top module
`default_nettype none
`include "port_alt_defines.vh"
module port_alt_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] ext_addr_lo,
  input wire [7:0] ext_data_out,
  input wire ext_write_strobe,
  input wire addr_phase,
  input wire [7:0] ext_data_in,
  input wire [7:0] port_a_pad_in,
  input wire [7:0] port_a_pad_out,
  input wire [7:0] port_a_pad_oe_n,
  input wire [7:0] port_a_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sre_q, pud_q, setup, wr_any, idle;
  logic [7:0] pa_out_q;
  assign setup = psel && !penable;
  assign wr_any = setup && pwrite;
  assign idle = !ext_write_strobe && !addr_phase;
  // ****************************************
  // Shadow of the written control bits and Port A output register
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sre_q <= 1'b0;
      pud_q <= 1'b0;
      pa_out_q <= 8'h00;
    end else if (wr_any) begin
      if (paddr == `ADDR_ALT_CTRL) sre_q <= pwdata[`BIT_EXT_MEM_ENABLE];
      if (paddr == `ADDR_MCU_CONTROL) pud_q <= pwdata[`BIT_GLOBAL_PULLUP_OFF];
      if (paddr == `ADDR_PORT_A_OUT) pa_out_q <= pwdata[7:0];
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence answer_s;
    pready && penable ##1 !pready;
  endsequence
  chk_apb_answer: assert property (setup |=> answer_s)
    else $error("access not answered in one cycle");
  chk_unmapped_err: assert property (setup && paddr > `ADDR_ALT_CTRL |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_addr_drive: assert property (sre_q && addr_phase && !ext_write_strobe && !wr_any
    |=> port_a_pad_out == $past(ext_addr_lo) && port_a_pad_oe_n == 8'h00) else $error("address not on port A");
  chk_data_drive: assert property (sre_q && ext_write_strobe && !addr_phase && !wr_any
    |=> port_a_pad_out == $past(ext_data_out) && port_a_pad_oe_n == 8'h00) else $error("write data not on port A");
  chk_bus_release: assert property (sre_q && idle && !wr_any |=> port_a_pad_oe_n == 8'hFF)
    else $error("idle bus still driven");
  chk_bus_pullup: assert property (sre_q && idle && !wr_any
    |=> port_a_pullup == ($past(pud_q) ? $past(pa_out_q) : 8'h00)) else $error("idle bus pull-up wrong");
  chk_pullup_off: assert property (pud_q && !sre_q && !wr_any |=> port_a_pullup == 8'h00)
    else $error("pull-up on while pull-ups off");
  chk_data_in_tap: assert property (reset_n |=> ext_data_in == $past(port_a_pad_in))
    else $error("data-in tap wrong");
endmodule
bind port_alt_function_override port_alt_chk port_alt_chk_i (.*);
`default_nettype wire

// *** bench/port_alt_function_override_test.sv ***
// Register-level testbench for the port override block
`default_nettype none
`include "port_alt_defines.vh"
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module port_alt_function_override_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, ext_write_strobe, addr_phase, prog_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] ext_addr_lo, ext_data_out, ext_data_in, pinchg_irq, drv_a_en, drv_a, drv_b_en, drv_b;
  logic t0_cmp_a_out, t0_cmp_a_en, t1_cmp_a_out, t1_cmp_a_en, t1_cmp_b_out, t1_cmp_b_en;
  logic t1_cmp_c_out, t1_cmp_c_en, t2_cmp_a_out, t2_cmp_a_en, spi_slave_out, spi_master_out, spi_sck_out;
  logic spi_master_in, spi_slave_in, spi_sck_in, spi_ss_in, prog_serial_in, prog_serial_out, e;
  logic debug_port_disable, vector_table_select, vector_change_unlock;
  logic [7:0] port_a_pad_in, port_a_pad_out, port_a_pad_oe_n, port_a_pullup;
  logic [7:0] port_b_pad_in, port_b_pad_out, port_b_pad_oe_n, port_b_pullup;
  int bad_count = 0;
  int samples_checked = 0;
  port_alt_function_override port_alt_function_override_i (.*);
  pad_far_side pad_far_side_a_i (.clk_sys(clk_sys), .pad_out(port_a_pad_out), .pad_oe_n(port_a_pad_oe_n),
    .pull_en(port_a_pullup), .drv_en(drv_a_en), .drv_val(drv_a), .pad_in(port_a_pad_in));
  pad_far_side pad_far_side_b_i (.clk_sys(clk_sys), .pad_out(port_b_pad_out), .pad_oe_n(port_b_pad_oe_n),
    .pull_en(port_b_pullup), .drv_en(drv_b_en), .drv_val(drv_b), .pad_in(port_b_pad_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // APB transfer, read data kept in r and error flag in e
  // ****************************************
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d});
  endtask
  task automatic tick();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_write_strobe, addr_phase, ext_addr_lo, ext_data_out} = '0;
    {t0_cmp_a_out, t0_cmp_a_en, t1_cmp_a_out, t1_cmp_a_en, t1_cmp_b_out, t1_cmp_b_en} = '0;
    {t1_cmp_c_out, t1_cmp_c_en, t2_cmp_a_out, t2_cmp_a_en, spi_slave_out, spi_master_out, spi_sck_out} = '0;
    {prog_mode, prog_serial_out, drv_a_en, drv_a, drv_b_en, drv_b} = '0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(`ADDR_MCU_CONTROL, 1'b0, 32'h0);
    `CHECK("ctl_reset", 32'h0, r)
    wr(`ADDR_MCU_CONTROL, 8'hFF);
    apb(`ADDR_MCU_CONTROL, 1'b0, 32'h0);
    `CHECK("ctl_mask", 32'h93, r)
    `CHECK("ctl_bits", 3'b111, {debug_port_disable, vector_table_select, vector_change_unlock})
    apb(12'h020, 1'b0, 32'h0);
    `CHECK("unmapped", 1'b1, e)
    `CHECK("unmapped_rd", 32'h0, r)
    wr(`ADDR_MCU_CONTROL, 8'h00);
    wr(`ADDR_PORT_A_OUT, 8'hA5);
    wr(`ADDR_PORT_B_OUT, 8'h3C);
    tick();
    `CHECK("pullup_a", 8'hA5, port_a_pullup)
    `CHECK("pullup_b", 8'h3C, port_b_pullup)
    wr(`ADDR_MCU_CONTROL, 8'h10);
    tick();
    `CHECK("pud_a", 8'h00, port_a_pullup)
    `CHECK("pud_b", 8'h00, port_b_pullup)
    wr(`ADDR_PORT_A_DIR, 8'hFF);
    wr(`ADDR_PORT_A_OUT, 8'h5A);
    tick();
    `CHECK("drive_a", 16'h5A00, {port_a_pad_out, port_a_pad_oe_n})
    wr(`ADDR_ALT_CTRL, 8'h01);
    @(posedge clk_sys);
    addr_phase <= 1'b1;
    ext_addr_lo <= 8'h96;
    tick();
    `CHECK("addr_out", 16'h9600, {port_a_pad_out, port_a_pad_oe_n})
    @(posedge clk_sys);
    addr_phase <= 1'b0;
    ext_write_strobe <= 1'b1;
    ext_data_out <= 8'h3B;
    tick();
    `CHECK("wdata_out", 16'h3B00, {port_a_pad_out, port_a_pad_oe_n})
    @(posedge clk_sys);
    ext_write_strobe <= 1'b0;
    drv_a_en <= 8'hFF;
    drv_a <= 8'hC4;
    tick();
    `CHECK("release", 8'hFF, port_a_pad_oe_n)
    `CHECK("bus_pullup", 8'h5A, port_a_pullup)
    `CHECK("rdata_in", 8'hC4, ext_data_in)
    wr(`ADDR_ALT_CTRL, 8'h00);
    wr(`ADDR_PORT_B_DIR, 8'hF0);
    wr(`ADDR_PORT_B_OUT, 8'h00);
    {t0_cmp_a_en, t1_cmp_c_en, t1_cmp_b_en, t1_cmp_a_en, t2_cmp_a_en} <= 5'h1F;
    {t0_cmp_a_out, t1_cmp_c_out, t1_cmp_b_out, t1_cmp_a_out, t2_cmp_a_out} <= 5'b01101;
    tick();
    `CHECK("timers", 4'h5, port_b_pad_out[7:4])
    `CHECK("pc_off", 8'h00, pinchg_irq)
    @(posedge clk_sys);
    t0_cmp_a_en <= 1'b0;
    tick();
    `CHECK("t1c_out", 4'hD, port_b_pad_out[7:4])
    wr(`ADDR_PORT_B_DIR, 8'h0F);
    wr(`ADDR_ALT_CTRL, 8'h0E);
    spi_master_out <= 1'b1;
    drv_b_en <= 8'h08;
    drv_b <= 8'h08;
    tick();
    `CHECK("mst_dir", 4'h8, port_b_pad_oe_n[3:0])
    `CHECK("mst_out", 2'b10, port_b_pad_out[2:1])
    `CHECK("miso_in", 2'b11, {spi_master_in, pinchg_irq[3]})
    wr(`ADDR_ALT_CTRL, 8'h0A);
    spi_slave_out <= 1'b1;
    drv_b_en <= 8'h07;
    drv_b <= 8'h06;
    tick();
    `CHECK("slv_dir", 4'h7, port_b_pad_oe_n[3:0])
    `CHECK("slv_out", 1'b1, port_b_pad_out[3])
    `CHECK("slv_in", 4'hE, {spi_slave_in, prog_serial_in, spi_sck_in, spi_ss_in})
    @(posedge clk_sys);
    prog_mode <= 1'b1;
    prog_serial_out <= 1'b0;
    tick();
    `CHECK("prog_out", 1'b0, port_b_pad_out[3])
    print_verdict();
  end
endmodule
`default_nettype wire

// *** hw/apb_reg_slave.v ***
// APB slave front end: single-cycle write strobe with access address and write data
`default_nettype none

module apb_reg_slave (
  input wire clk_sys,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [7:0] rd_value,
  input wire rd_hit,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg pready,
  output wire wr_stb,
  output wire [11:0] acc_addr,
  output wire [7:0] wr_data
);
  // ****************************************
  // Zero-wait access; ready registered in setup
  // ****************************************
  wire setup_wr = psel & ~penable & pwrite;

  assign wr_stb = setup_wr;
  assign acc_addr = paddr;
  assign wr_data = pwdata[7:0];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      // Writes and unmapped reads return zero
      if (psel & ~penable) begin
        prdata <= {24'h000000, (rd_hit & ~pwrite) ? rd_value : 8'h00};
      end
    end
  end
endmodule

`default_nettype wire

// *** hw/pin_override_cell.v ***
// One port pin: register bits combined with alternate-function overrides
`default_nettype none

module pin_override_cell (
  input wire dir_bit,
  input wire out_bit,
  input wire global_pullup_off,
  input wire pullup_override_en,
  input wire pullup_override_val,
  input wire dir_override_en,
  input wire dir_override_val,
  input wire value_override_en,
  input wire value_override_val,
  input wire input_en_override_en,
  input wire input_en_override_val,
  input wire pad_in,
  output wire pad_out,
  output wire pad_oe_n,
  output wire pullup_on,
  output wire input_en,
  output wire pin_input_tap
);
  `include "port_alt_defines.vh"

  wire drive_on;

  // Pull-up follows override, else only for code 010
  assign pullup_on = pullup_override_en ? pullup_override_val :
    ({dir_bit, out_bit, global_pullup_off} == `PULLUP_ON_CODE);
  assign drive_on = dir_override_en ? dir_override_val : dir_bit;
  assign pad_out = value_override_en ? value_override_val : out_bit;
  assign pad_oe_n = ~drive_on;
  assign input_en = input_en_override_en ? input_en_override_val : 1'b1;
  assign pin_input_tap = pad_in;
endmodule

`default_nettype wire

// *** hw/port_alt_defines.vh ***
// Offsets, field positions, reset values and encodings for the port override block
`ifndef PORT_ALT_DEFINES_VH
`define PORT_ALT_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_MCU_CONTROL 12'h000
`define ADDR_PORT_A_OUT 12'h004
`define ADDR_PORT_A_DIR 12'h008
`define ADDR_PORT_A_PIN 12'h00C
`define ADDR_PORT_B_OUT 12'h010
`define ADDR_PORT_B_DIR 12'h014
`define ADDR_PORT_B_PIN 12'h018
`define ADDR_ALT_CTRL 12'h01C

// ****************************************
// Control register fields
// ****************************************
`define BIT_DEBUG_PORT_DISABLE 7
`define BIT_GLOBAL_PULLUP_OFF 4
`define BIT_VECTOR_TABLE_SELECT 1
`define BIT_VECTOR_CHANGE_UNLOCK 0
`define MCU_CONTROL_WMASK 8'h93
`define MCU_CONTROL_RESET 8'h00

// ****************************************
// Alternate-function control fields
// ****************************************
`define BIT_EXT_MEM_ENABLE 0
`define BIT_SPI_ENABLE 1
`define BIT_SPI_MASTER 2
`define BIT_PINCHG_ENABLE 3
`define ALT_CTRL_WMASK 8'h0F
`define ALT_CTRL_RESET 8'h00

`define PORT_RESET 8'h00
`define PULLUP_ON_CODE 3'b010

`endif

// *** hw/port_alt_function_override.v ***
// Port A/B pin override logic with control registers on APB
//
// Notes on behaviour
// - When global pull-up-off is set, only the Port A bus and SPI-master Port B pull-up overrides can turn a pull-up on.
// - The control register holds debug-port disable bit 7, pull-up-off bit 4, vector select bit 1, unlock bit 0.
// - Port A becomes the multiplexed low address and data bus when external memory is enabled.
// - Port A pin n carries multiplexed bus bit n.
// - External-memory enable drives pull-up, direction and value override enables; input overrides stay 0.
// - Direction override is write strobe OR address phase; value is address in address phase, data on write.
// - Pull-up override value is idle-bus AND output bit AND pull-up-disable term; pin input feeds data-in.
// - Address phase is asserted one cycle before the address is driven on Port A, which comes from the output flops.
// - Port B pin 7 offers timer 0 A, timer 1 C and pin-change source 7.
// - Port B pins 6, 5, 4 offer timer 1 B, timer 1 A, timer 2 A and pin-change sources 6, 5, 4.
// - Port B pin 3 carries programming out and MISO, pin 2 programming in and MOSI, plus pin-change 3, 2.
// - Port B pin 1 carries SCK, pin 0 slave select, plus pin-change 1, 0.
// - Pull-up follows its override when enabled, else only direction/output/pull-up-off equal 010.
// - An enabled driver outputs the override value when enabled, else the output register bit.
// - With SPI master, Port B pin 3 is forced input while its output bit still steers the pull-up.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none

module port_alt_function_override (
  input wire clk_sys,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] ext_addr_lo,
  input wire [7:0] ext_data_out,
  input wire ext_write_strobe,
  input wire addr_phase,
  output reg [7:0] ext_data_in,
  input wire t0_cmp_a_out,
  input wire t0_cmp_a_en,
  input wire t1_cmp_a_out,
  input wire t1_cmp_a_en,
  input wire t1_cmp_b_out,
  input wire t1_cmp_b_en,
  input wire t1_cmp_c_out,
  input wire t1_cmp_c_en,
  input wire t2_cmp_a_out,
  input wire t2_cmp_a_en,
  input wire spi_slave_out,
  input wire spi_master_out,
  input wire spi_sck_out,
  output reg spi_master_in,
  output reg spi_slave_in,
  output reg spi_sck_in,
  output reg spi_ss_in,
  output reg prog_serial_in,
  input wire prog_serial_out,
  input wire prog_mode,
  output reg [7:0] pinchg_irq,
  input wire [7:0] port_a_pad_in,
  output reg [7:0] port_a_pad_out,
  output reg [7:0] port_a_pad_oe_n,
  output reg [7:0] port_a_pullup,
  input wire [7:0] port_b_pad_in,
  output reg [7:0] port_b_pad_out,
  output reg [7:0] port_b_pad_oe_n,
  output reg [7:0] port_b_pullup,
  output reg debug_port_disable,
  output reg vector_table_select,
  output reg vector_change_unlock
);
  `include "port_alt_defines.vh"

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] mcu_control_q;
  reg [7:0] alt_ctrl_q;
  reg [7:0] port_a_out_q;
  reg [7:0] port_a_dir_q;
  reg [7:0] port_b_out_q;
  reg [7:0] port_b_dir_q;

  wire wr_stb;
  wire [11:0] acc_addr;
  wire [7:0] wr_data;
  reg [7:0] rd_value;
  reg rd_hit;

  wire global_pullup_off = mcu_control_q[`BIT_GLOBAL_PULLUP_OFF];
  wire ext_mem_enable = alt_ctrl_q[`BIT_EXT_MEM_ENABLE];
  wire spi_enable = alt_ctrl_q[`BIT_SPI_ENABLE];
  wire spi_master = alt_ctrl_q[`BIT_SPI_MASTER];
  wire pinchg_enable = alt_ctrl_q[`BIT_PINCHG_ENABLE];
  wire spi_is_master = spi_enable & spi_master;
  wire spi_is_slave = spi_enable & ~spi_master;

  apb_reg_slave u_apb (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rd_value(rd_value),
    .rd_hit(rd_hit),
    .prdata(prdata),
    .pslverr(pslverr),
    .pready(pready),
    .wr_stb(wr_stb),
    .acc_addr(acc_addr),
    .wr_data(wr_data)
  );

  // ****************************************
  // Register write
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mcu_control_q <= `MCU_CONTROL_RESET;
      alt_ctrl_q <= `ALT_CTRL_RESET;
      port_a_out_q <= `PORT_RESET;
      port_a_dir_q <= `PORT_RESET;
      port_b_out_q <= `PORT_RESET;
      port_b_dir_q <= `PORT_RESET;
    end else if (wr_stb) begin
      case (acc_addr)
        `ADDR_MCU_CONTROL: mcu_control_q <= wr_data & `MCU_CONTROL_WMASK;
        `ADDR_ALT_CTRL: alt_ctrl_q <= wr_data & `ALT_CTRL_WMASK;
        `ADDR_PORT_A_OUT: port_a_out_q <= wr_data;
        `ADDR_PORT_A_DIR: port_a_dir_q <= wr_data;
        `ADDR_PORT_B_OUT: port_b_out_q <= wr_data;
        `ADDR_PORT_B_DIR: port_b_dir_q <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always @* begin
    rd_hit = 1'b1;
    case (acc_addr)
      `ADDR_MCU_CONTROL: rd_value = mcu_control_q;
      `ADDR_ALT_CTRL: rd_value = alt_ctrl_q;
      `ADDR_PORT_A_OUT: rd_value = port_a_out_q;
      `ADDR_PORT_A_DIR: rd_value = port_a_dir_q;
      `ADDR_PORT_A_PIN: rd_value = port_a_pad_in;
      `ADDR_PORT_B_OUT: rd_value = port_b_out_q;
      `ADDR_PORT_B_DIR: rd_value = port_b_dir_q;
      `ADDR_PORT_B_PIN: rd_value = port_b_pad_in;
      default: begin
        rd_value = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Port A overrides (external memory bus)
  // ****************************************
  wire bus_busy = ext_write_strobe | addr_phase;
  wire [7:0] a_pullup_override_en = {8{ext_mem_enable}};
  // Pull-up-disable term used exactly as printed
  wire [7:0] a_pullup_override_val = {8{~bus_busy & global_pullup_off}} & port_a_out_q;
  wire [7:0] a_dir_override_val = {8{bus_busy}};
  // Address while the address phase is active, data while writing
  wire [7:0] a_value_override_val = (ext_addr_lo & {8{addr_phase}}) | (ext_data_out & {8{ext_write_strobe}});

  // ****************************************
  // Port B overrides
  // ****************************************
  wire [7:0] b_pullup_override_en;
  wire [7:0] b_pullup_override_val;
  wire [7:0] b_dir_override_en;
  wire [7:0] b_dir_override_val;
  wire [7:0] b_value_override_en;
  wire [7:0] b_value_override_val;

  assign b_pullup_override_en = {4'h0, {4{spi_is_master}}};
  assign b_pullup_override_val = {4'h0, port_b_out_q[3:0] & {4{global_pullup_off}}};
  // Pin 3 forced input as master; pins 2..0 forced input as slave
  assign b_dir_override_en = {4'h0, spi_is_master, {3{spi_is_slave}}};
  assign b_dir_override_val = 8'h00;
  assign b_value_override_en = {t0_cmp_a_en | t1_cmp_c_en, t1_cmp_b_en, t1_cmp_a_en, t2_cmp_a_en,
                   spi_is_slave | prog_mode, {2{spi_is_master}}, 1'b0};
  assign b_value_override_val = {t0_cmp_a_en ? t0_cmp_a_out : t1_cmp_c_out, t1_cmp_b_out, t1_cmp_a_out, t2_cmp_a_out,
                   prog_mode ? prog_serial_out : spi_slave_out, spi_master_out, spi_sck_out, 1'b0};

  // ****************************************
  // Per-pin combiners
  // ****************************************
  wire [7:0] a_out_c;
  wire [7:0] a_oe_n_c;
  wire [7:0] a_pu_c;
  wire [7:0] a_di_c;
  wire [7:0] b_out_c;
  wire [7:0] b_oe_n_c;
  wire [7:0] b_pu_c;
  wire [7:0] b_di_c;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pin_override_cell u_a (
        .dir_bit(port_a_dir_q[gi]),
        .out_bit(port_a_out_q[gi]),
        .global_pullup_off(global_pullup_off),
        .pullup_override_en(a_pullup_override_en[gi]),
        .pullup_override_val(a_pullup_override_val[gi]),
        .dir_override_en(a_pullup_override_en[gi]),
        .dir_override_val(a_dir_override_val[gi]),
        .value_override_en(a_pullup_override_en[gi]),
        .value_override_val(a_value_override_val[gi]),
        .input_en_override_en(1'b0),
        .input_en_override_val(1'b0),
        .pad_in(port_a_pad_in[gi]),
        .pad_out(a_out_c[gi]),
        .pad_oe_n(a_oe_n_c[gi]),
        .pullup_on(a_pu_c[gi]),
        .input_en(),
        .pin_input_tap(a_di_c[gi])
      );
      pin_override_cell u_b (
        .dir_bit(port_b_dir_q[gi]),
        .out_bit(port_b_out_q[gi]),
        .global_pullup_off(global_pullup_off),
        .pullup_override_en(b_pullup_override_en[gi]),
        .pullup_override_val(b_pullup_override_val[gi]),
        .dir_override_en(b_dir_override_en[gi]),
        .dir_override_val(b_dir_override_val[gi]),
        .value_override_en(b_value_override_en[gi]),
        .value_override_val(b_value_override_val[gi]),
        .input_en_override_en(pinchg_enable),
        .input_en_override_val(1'b1),
        .pad_in(port_b_pad_in[gi]),
        .pad_out(b_out_c[gi]),
        .pad_oe_n(b_oe_n_c[gi]),
        .pullup_on(b_pu_c[gi]),
        .input_en(),
        .pin_input_tap(b_di_c[gi])
      );
    end
  endgenerate

  // ****************************************
  // Output flops
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_a_pad_out <= 8'h00;
      port_a_pad_oe_n <= 8'hFF;
      port_a_pullup <= 8'h00;
      port_b_pad_out <= 8'h00;
      port_b_pad_oe_n <= 8'hFF;
      port_b_pullup <= 8'h00;
      ext_data_in <= 8'h00;
      pinchg_irq <= 8'h00;
      spi_master_in <= 1'b0;
      spi_slave_in <= 1'b0;
      spi_sck_in <= 1'b0;
      spi_ss_in <= 1'b1;
      prog_serial_in <= 1'b0;
      debug_port_disable <= 1'b0;
      vector_table_select <= 1'b0;
      vector_change_unlock <= 1'b0;
    end else begin
      port_a_pad_out <= a_out_c;
      port_a_pad_oe_n <= a_oe_n_c;
      port_a_pullup <= a_pu_c;
      port_b_pad_out <= b_out_c;
      port_b_pad_oe_n <= b_oe_n_c;
      port_b_pullup <= b_pu_c;
      ext_data_in <= a_di_c;
      pinchg_irq <= b_di_c & {8{pinchg_enable}};
      spi_master_in <= b_di_c[3];
      spi_slave_in <= b_di_c[2];
      prog_serial_in <= b_di_c[2];
      spi_sck_in <= b_di_c[1];
      spi_ss_in <= b_di_c[0];
      debug_port_disable <= mcu_control_q[`BIT_DEBUG_PORT_DISABLE];
      vector_table_select <= mcu_control_q[`BIT_VECTOR_TABLE_SELECT];
      vector_change_unlock <= mcu_control_q[`BIT_VECTOR_CHANGE_UNLOCK];
    end
  end
endmodule

`default_nettype wire
